/* pll_pkg.sv */
// Shared constants for the synthesizer divider and lock detector logic
package pll_pkg;
   // Clock and window timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int ONESHOT_NS = 10;
   localparam int ONESHOT_CYC_I = (ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Reference path divider
   localparam int REF_DIV_W = 14;
   localparam logic [REF_DIV_W-1:0] REF_DIV_MIN = 14'h0001;
   localparam logic [REF_DIV_W-1:0] REF_DIV_MAX = 14'h3fff;
   // RF path divider, wide enough for the integer-mode maximum
   localparam int N_DIV_W = 17;
   localparam logic [N_DIV_W-1:0] N_FRAC_MIN = 17'h00024;
   localparam logic [N_DIV_W-1:0] N_FRAC_MAX = 17'h0ffff;
   localparam logic [N_DIV_W-1:0] N_INT_MIN = 17'h00020;
   localparam logic [N_DIV_W-1:0] N_INT_MAX = 17'h1001f;
   // Lock detector fields
   localparam int WINCNT_W = 16;
   localparam int GAP_W = 16;
   localparam int RING_CFG_W = 4;
   localparam int ONESHOT_DUR_W = 8;
   localparam logic [GAP_W-1:0] ONESHOT_CYC = GAP_W'(ONESHOT_CYC_I);
   localparam logic [GAP_W-1:0] GAP_SAT = 16'hffff;
   // Reset values
   localparam logic [WINCNT_W-1:0] WINCNT_RST = 16'h0000;
   localparam logic [GAP_W-1:0] GAP_RST = 16'h0000;
endpackage : pll_pkg

/* tick_if.sv */
// One-cycle event carrier between the synchronizer, the dividers and the top
interface tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface : tick_if

/* edge_sync.sv */
// Two-flop synchronizer with rising-edge detect for an asynchronous pin
module edge_sync (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Pin
   input wire logic i_pin,
   // Rising-edge event
   tick_if.src o_edge
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
      logic rise;
   } sync_state_t;

   sync_state_t cur;
   sync_state_t next_cur;

   always_comb begin
      next_cur = cur;
      next_cur.meta = i_pin;
      next_cur.sync = cur.meta;
      // Only the second stage feeds the edge detector
      next_cur.prev = cur.sync;
      next_cur.rise = cur.sync & ~cur.prev;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign o_edge.tick = cur.rise;
endmodule : edge_sync

/* pulse_divider.sv */
// Event divider: one output event for every ratio input events
module pulse_divider
   import pll_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Ratio, already clamped by the caller to at least one
   input wire logic [N_DIV_W-1:0] i_ratio,
   // Events in and out
   tick_if.dst i_in,
   tick_if.src o_out
);
   typedef struct packed {
      logic [N_DIV_W-1:0] count;
      logic out;
   } div_state_t;

   div_state_t cur;
   div_state_t next_cur;

   always_comb begin
      next_cur = cur;
      next_cur.out = 1'b0;
      if (i_in.tick) begin
         // Compare with >= so a ratio lowered mid-count cannot strand the counter
         if (cur.count + 17'h00001 >= i_ratio) begin
            next_cur.count = '0;
            next_cur.out = 1'b1;
         end else begin
            next_cur.count = cur.count + 17'h00001;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign o_out.tick = cur.out;
endmodule : pulse_divider

/* pll_core.sv */
// Synthesizer digital core: dividers, phase detector with test controls, lock detector
// Operation
// [RULE1] Reference divider 14-bit, ratio 1 to 16383
// [RULE2] Fractional mode RF ratio 36 to 65535
// [RULE3] Integer mode RF ratio 32 to 65567
// [RULE4] Detector compares divided reference and RF
// [RULE5] Polarity select swaps up and down
// [RULE6] Cleared up enable masks up output
// [RULE7] Cleared down enable masks down output
// [RULE8] Both cleared puts pump high impedance
// [RULE9] Lock detect runs only when enabled
// [RULE10] Window around reference edge checks VCO
// [RULE11] Select cleared: fixed 10 ns window
// [RULE12] Select set: ring periods times count
// [RULE13] Lock after programmed consecutive hits
// [RULE14] One miss clears lock until recount
// [RULE15] Lock flag always readable as status
// [RULE16] Pin shows lock, or read data
// [RULE17] Asymmetric window for delay or advance
// [RULE18] Hit counter: once per compare, saturates
module pll_core
   import pll_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Oscillator inputs, asynchronous
   input wire logic i_ref_in,
   input wire logic i_vco_in,
   // Divider configuration
   input wire logic [REF_DIV_W-1:0] i_ref_ratio,
   input wire logic [N_DIV_W-1:0] i_rf_ratio,
   input wire logic i_frac_mode,
   // Phase detector test controls
   input wire logic i_pump_polarity_swap,
   input wire logic i_pump_up_request_enable,
   input wire logic i_pump_down_request_enable,
   // Lock detector configuration
   input wire logic i_lock_detect_enable,
   input wire logic i_ring_window_sel,
   input wire logic [RING_CFG_W-1:0] i_ring_period_cfg,
   input wire logic [ONESHOT_DUR_W-1:0] i_ring_window_count,
   input wire logic [WINCNT_W-1:0] i_lock_hit_target,
   input wire logic i_win_asym_enable,
   input wire logic i_win_delay_sel,
   // Shared pin and serial readback
   input wire logic i_lock_flag_pin_enable,
   input wire logic i_serial_read_active,
   input wire logic i_serial_read_data,
   // Charge pump requests
   output logic o_cp_up,
   output logic o_cp_dn,
   output logic o_cp_hiz,
   // Divided event monitors
   output logic o_ref_div_tick,
   output logic o_vco_div_tick,
   // Lock status
   output logic o_lock_status,
   output logic o_lock_or_readback_pin
);
   typedef struct packed {
      logic pfd_up;
      logic pfd_dn;
      logic cp_up;
      logic cp_dn;
      logic cp_hiz;
      logic seen_ref;
      logic seen_vco;
      logic [GAP_W-1:0] gap;
      logic [WINCNT_W-1:0] hit_cnt;
      logic lock;
      logic pin;
   } core_state_t;

   core_state_t cur;
   core_state_t next_cur;

   tick_if ref_raw ();
   tick_if vco_raw ();
   tick_if ref_div ();
   tick_if vco_div ();

   logic [N_DIV_W-1:0] ref_ratio_eff;
   logic [N_DIV_W-1:0] rf_ratio_eff;

   // Out-of-range ratios are clamped rather than passed, so the loop never divides by zero
   always_comb begin
      if (i_ref_ratio < REF_DIV_MIN) begin
         ref_ratio_eff = N_DIV_W'(REF_DIV_MIN); // [RULE1]
      end else if (i_ref_ratio > REF_DIV_MAX) begin
         ref_ratio_eff = N_DIV_W'(REF_DIV_MAX); // [RULE1]
      end else begin
         ref_ratio_eff = N_DIV_W'(i_ref_ratio);
      end
   end

   always_comb begin
      rf_ratio_eff = i_rf_ratio;
      if (i_frac_mode) begin
         if (i_rf_ratio < N_FRAC_MIN) begin
            rf_ratio_eff = N_FRAC_MIN; // [RULE2]
         end else if (i_rf_ratio > N_FRAC_MAX) begin
            rf_ratio_eff = N_FRAC_MAX; // [RULE2]
         end
      end else begin
         if (i_rf_ratio < N_INT_MIN) begin
            rf_ratio_eff = N_INT_MIN; // [RULE3]
         end else if (i_rf_ratio > N_INT_MAX) begin
            rf_ratio_eff = N_INT_MAX; // [RULE3]
         end
      end
   end

   edge_sync u_ref_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst_b (i_rst_b),
      .i_pin (i_ref_in),
      .o_edge (ref_raw.src)
   );

   edge_sync u_vco_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst_b (i_rst_b),
      .i_pin (i_vco_in),
      .o_edge (vco_raw.src)
   );

   pulse_divider u_ref_div (
      .i_sys_clk (i_sys_clk),
      .i_rst_b (i_rst_b),
      .i_ratio (ref_ratio_eff),
      .i_in (ref_raw.dst),
      .o_out (ref_div.src)
   );

   // Average fractional modulation of the ratio lies outside this block
   pulse_divider u_rf_div (
      .i_sys_clk (i_sys_clk),
      .i_rst_b (i_rst_b),
      .i_ratio (rf_ratio_eff),
      .i_in (vco_raw.dst),
      .o_out (vco_div.src)
   );

   // Window half-width in system cycles
   logic [GAP_W-1:0] win_cyc;
   logic [GAP_W:0] late_lim;
   logic [GAP_W:0] early_lim;
   logic [GAP_W+RING_CFG_W:0] ring_win;

   always_comb begin
      ring_win = (GAP_W+RING_CFG_W+1)'(i_ring_window_count) * (GAP_W+RING_CFG_W+1)'({1'b0, i_ring_period_cfg} + 5'h01);
      if (i_ring_window_sel) begin
         win_cyc = (ring_win > (GAP_W+RING_CFG_W+1)'(GAP_SAT)) ? GAP_SAT : ring_win[GAP_W-1:0]; // [RULE12]
      end else begin
         win_cyc = ONESHOT_CYC; // [RULE11]
      end
      if (i_win_asym_enable && i_win_delay_sel) begin
         late_lim = {win_cyc, 1'b0}; // [RULE17]
         early_lim = '0;
      end else if (i_win_asym_enable) begin
         late_lim = '0;
         early_lim = {win_cyc, 1'b0}; // [RULE17]
      end else begin
         late_lim = {1'b0, win_cyc};
         early_lim = {1'b0, win_cyc};
      end
   end

   logic r;
   logic v;
   logic pa;
   logic pb;
   logic swap_up;
   logic swap_dn;
   logic cmp_done;
   logic cmp_hit;
   logic [GAP_W:0] gap_p1;

   assign r = ref_div.tick;
   assign v = vco_div.tick;
   assign gap_p1 = {1'b0, cur.gap} + 17'h00001;

   always_comb begin
      next_cur = cur;
      cmp_done = 1'b0;
      cmp_hit = 1'b0;

      // Reference edge sets up, divided VCO edge sets down, both clear together
      pa = cur.pfd_up | r; // [RULE4]
      pb = cur.pfd_dn | v; // [RULE4]
      if (pa && pb) begin
         next_cur.pfd_up = 1'b0;
         next_cur.pfd_dn = 1'b0;
      end else begin
         next_cur.pfd_up = pa;
         next_cur.pfd_dn = pb;
      end
      swap_up = i_pump_polarity_swap ? next_cur.pfd_dn : next_cur.pfd_up; // [RULE5]
      swap_dn = i_pump_polarity_swap ? next_cur.pfd_up : next_cur.pfd_dn; // [RULE5]
      next_cur.cp_up = swap_up & i_pump_up_request_enable; // [RULE6]
      next_cur.cp_dn = swap_dn & i_pump_down_request_enable; // [RULE7]
      next_cur.cp_hiz = ~i_pump_up_request_enable & ~i_pump_down_request_enable; // [RULE8]

      // A comparison pairs one reference edge with one VCO edge, or ends as a miss on two edges of the same kind
      if (!i_lock_detect_enable) begin
         next_cur.seen_ref = 1'b0; // [RULE9]
         next_cur.seen_vco = 1'b0;
         next_cur.gap = GAP_RST;
         next_cur.hit_cnt = WINCNT_RST;
         next_cur.lock = 1'b0; // [RULE9]
      end else if (!cur.seen_ref && !cur.seen_vco) begin
         if (r && v) begin
            cmp_done = 1'b1;
            cmp_hit = 1'b1; // [RULE10]
         end else begin
            next_cur.seen_ref = r;
            next_cur.seen_vco = v;
            next_cur.gap = GAP_RST;
         end
      end else if (cur.seen_ref && v) begin
         cmp_done = 1'b1;
         cmp_hit = gap_p1 <= late_lim; // [RULE10]
         next_cur.seen_ref = r;
         next_cur.seen_vco = 1'b0;
         next_cur.gap = GAP_RST;
      end else if (cur.seen_vco && r) begin
         cmp_done = 1'b1;
         cmp_hit = gap_p1 <= early_lim; // [RULE10]
         next_cur.seen_vco = v;
         next_cur.seen_ref = 1'b0;
         next_cur.gap = GAP_RST;
      end else if ((cur.seen_ref && r) || (cur.seen_vco && v)) begin
         // A second edge of the same kind means the other one never landed
         cmp_done = 1'b1;
         cmp_hit = 1'b0;
         next_cur.gap = GAP_RST;
      end else if (cur.gap != GAP_SAT) begin
         next_cur.gap = cur.gap + 16'h0001;
      end

      if (cmp_done) begin
         if (!cmp_hit) begin
            next_cur.hit_cnt = WINCNT_RST; // [RULE18]
            next_cur.lock = 1'b0; // [RULE14]
         end else begin
            if (cur.hit_cnt < i_lock_hit_target) begin
               next_cur.hit_cnt = cur.hit_cnt + 16'h0001; // [RULE18]
            end
            next_cur.lock = (next_cur.hit_cnt >= i_lock_hit_target); // [RULE13]
         end
      end

      // Readback owns the pin while a serial read is in progress
      if (i_serial_read_active) begin
         next_cur.pin = i_serial_read_data; // [RULE16]
      end else begin
         next_cur.pin = i_lock_flag_pin_enable & next_cur.lock; // [RULE16]
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign o_cp_up = cur.cp_up;
   assign o_cp_dn = cur.cp_dn;
   assign o_cp_hiz = cur.cp_hiz;
   assign o_ref_div_tick = r;
   assign o_vco_div_tick = v;
   assign o_lock_status = cur.lock; // [RULE15]
   assign o_lock_or_readback_pin = cur.pin;
endmodule : pll_core

/* pll_core_sva.sv */
// Concurrent checks on the synthesizer core ports
module pll_core_sva (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Controls
   input wire logic i_pump_polarity_swap,
   input wire logic i_pump_up_request_enable,
   input wire logic i_pump_down_request_enable,
   input wire logic i_lock_detect_enable,
   input wire logic i_lock_flag_pin_enable,
   input wire logic i_serial_read_active,
   input wire logic i_serial_read_data,
   // Watched outputs
   input wire logic o_cp_up,
   input wire logic o_cp_dn,
   input wire logic o_cp_hiz,
   input wire logic o_ref_div_tick,
   input wire logic o_vco_div_tick,
   input wire logic o_lock_status,
   input wire logic o_lock_or_readback_pin
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   // Pin phases of two cycles or more keep divided ticks at least four cycles apart
   sequence s_ref_quiet;
      !o_ref_div_tick [*3];
   endsequence
   sequence s_vco_quiet;
      !o_vco_div_tick [*3];
   endsequence
   // The first edge after reset still shows the reset value, so it is skipped
   property p_hiz;
      $past(i_rst_b) |-> o_cp_hiz == $past(!i_pump_up_request_enable && !i_pump_down_request_enable);
   endproperty
   property p_up_mask;
      !$past(i_pump_up_request_enable) |-> !o_cp_up;
   endproperty
   property p_dn_mask;
      !$past(i_pump_down_request_enable) |-> !o_cp_dn;
   endproperty
   // A control change can unmask a pending request, so only rises under steady controls need a tick
   property p_up_src;
      $rose(o_cp_up) && $past(i_pump_up_request_enable, 2) &&
         $past(i_pump_polarity_swap) == $past(i_pump_polarity_swap, 2) |->
         $past(i_pump_polarity_swap ? o_vco_div_tick : o_ref_div_tick);
   endproperty
   property p_dn_src;
      $rose(o_cp_dn) && $past(i_pump_down_request_enable, 2) &&
         $past(i_pump_polarity_swap) == $past(i_pump_polarity_swap, 2) |->
         $past(i_pump_polarity_swap ? o_ref_div_tick : o_vco_div_tick);
   endproperty
   property p_lock_off;
      !$past(i_lock_detect_enable) |-> !o_lock_status;
   endproperty
   property p_lock_rise;
      $rose(o_lock_status) |-> $past(o_ref_div_tick || o_vco_div_tick);
   endproperty
   property p_lock_fall;
      $fell(o_lock_status) |-> $past(o_ref_div_tick || o_vco_div_tick || !i_lock_detect_enable);
   endproperty
   property p_pin;
      $past(i_rst_b) |-> o_lock_or_readback_pin == ($past(i_serial_read_active) ? $past(i_serial_read_data)
         : $past(i_lock_flag_pin_enable) && o_lock_status);
   endproperty
   property p_ref_gap;
      o_ref_div_tick |=> s_ref_quiet;
   endproperty
   property p_vco_gap;
      o_vco_div_tick |=> s_vco_quiet;
   endproperty
   a_hiz: assert property (p_hiz) else $error("pump high impedance wrong");
   a_up_mask: assert property (p_up_mask) else $error("up not masked");
   a_dn_mask: assert property (p_dn_mask) else $error("down not masked");
   a_up_src: assert property (p_up_src) else $error("up without its tick");
   a_dn_src: assert property (p_dn_src) else $error("down without its tick");
   a_lock_off: assert property (p_lock_off) else $error("lock while disabled");
   a_lock_rise: assert property (p_lock_rise) else $error("lock rose without compare");
   a_lock_fall: assert property (p_lock_fall) else $error("lock fell without compare");
   a_pin: assert property (p_pin) else $error("shared pin wrong");
   a_ref_gap: assert property (p_ref_gap) else $error("reference ticks too close");
   a_vco_gap: assert property (p_vco_gap) else $error("vco ticks too close");
endmodule : pll_core_sva

bind pll_core pll_core_sva chk_u (.*);

/* osc_model.sv */
// Reference and VCO oscillator pair driving the core's pins
module osc_model (
   // Clock and control
   input wire logic i_sys_clk,
   input wire logic i_run,
   input wire logic [7:0] i_ref_half,
   input wire logic [7:0] i_vco_half,
   input wire logic [7:0] i_ref_lag,
   input wire logic [7:0] i_vco_lag,
   // Pins
   output logic o_ref,
   output logic o_vco
);
   timeunit 1ns;
   timeprecision 1ps;
   int rc;
   int vc;
   // Pins rest low outside a run so no stray edge reaches the dividers
   always @(negedge i_sys_clk) begin
      if (!i_run) begin
         rc <= -int'(i_ref_lag);
         vc <= -int'(i_vco_lag);
         o_ref <= 1'b0;
         o_vco <= 1'b0;
      end else begin
         rc <= (rc + 1 == int'(i_ref_half)) ? 0 : rc + 1;
         vc <= (vc + 1 == int'(i_vco_half)) ? 0 : vc + 1;
         if (rc + 1 == int'(i_ref_half)) o_ref <= ~o_ref;
         if (vc + 1 == int'(i_vco_half)) o_vco <= ~o_vco;
      end
   end
endmodule : osc_model

/* pll_core_bench.sv */
// Self-checking bench for the synthesizer digital core
module pll_core_bench
   import pll_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, run, rf_pin, vc_pin;
   logic [7:0] hr, hv, rl, vl;
   logic [REF_DIV_W-1:0] rr;
   logic [N_DIV_W-1:0] nr;
   logic fr, sw, upe, dne, lde, sel, asy, dly, pen, rda, rdd;
   logic up, dn, hiz, rt, vt, lock_s, pin;
   logic pin_due, pin_exp;
   int seed, num_errors, total_checks, hit, drop, eri, evi, m, cyc, rlast, vlast, tmp;
   logic [15:0] viv;
   logic [7:0] uc, dc;
   logic [49:0] exp_q[$];
   osc_model osc_u (.i_sys_clk(clk), .i_run(run), .i_ref_half(hr), .i_vco_half(hv), .i_ref_lag(rl),
      .i_vco_lag(vl), .o_ref(rf_pin), .o_vco(vc_pin));
   pll_core dut_u (.i_sys_clk(clk), .i_rst_b(rst_b), .i_ref_in(rf_pin), .i_vco_in(vc_pin), .i_ref_ratio(rr),
      .i_rf_ratio(nr), .i_frac_mode(fr), .i_pump_polarity_swap(sw), .i_pump_up_request_enable(upe),
      .i_pump_down_request_enable(dne), .i_lock_detect_enable(lde), .i_ring_window_sel(sel),
      .i_ring_period_cfg(4'h1), .i_ring_window_count(8'h02), .i_lock_hit_target(16'h0003),
      .i_win_asym_enable(asy), .i_win_delay_sel(dly), .i_lock_flag_pin_enable(pen),
      .i_serial_read_active(rda), .i_serial_read_data(rdd), .o_cp_up(up), .o_cp_dn(dn), .o_cp_hiz(hiz),
      .o_ref_div_tick(rt), .o_vco_div_tick(vt), .o_lock_status(lock_s), .o_lock_or_readback_pin(pin));
   task automatic check(input logic [49:0] seen, input logic [49:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      if (num_errors == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   task automatic wait_tick();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rt !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         num_errors++;
         final_report();
      end
   endtask : wait_tick
   // Each case restarts from reset so divider counts never carry over between cases
   task automatic go();
      int k;
      int r;
      logic psw, pup, pdn;
      logic [7:0] ue, de;
      @(negedge clk);
      rst_b = 1'b0;
      run = 1'b0;
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      run = 1'b1;
      for (k = 1; k <= 6; k++) begin
         wait_tick();
         @(negedge clk);
         r = $random(seed);
         {psw, pup, pdn} = {sw, upe, dne};
         sw = r[0];
         upe = r[1] & m[0];
         dne = r[2] & m[0];
         if (k == drop) sel = 1'b0;
         // The first cycle of a late VCO pulse is registered before the new controls arrive
         ue = 8'(vl != 0 && !psw && pup) + ((vl != 0 && !sw && upe) ? vl - 8'h01 : 8'h00) +
            ((sw && upe) ? rl : 8'h00);
         de = 8'(vl != 0 && psw && pdn) + ((vl != 0 && sw && dne) ? vl - 8'h01 : 8'h00) +
            ((!sw && dne) ? rl : 8'h00);
         if (k >= 2) exp_q.push_back({1'(lde && hit != 0 && k >= 3 && k < drop), ue, de, ~upe & ~dne,
            16'(eri), 16'(evi)});
      end
      wait_tick();
   endtask : go
   task automatic lock_case(input logic [7:0] a, input logic [7:0] b, input logic s, input logic y,
      input logic d, input logic e, input int h, input int p);
      {rl, vl, sel, asy, dly, lde, hit, drop} = {a, b, s, y, d, e, h, p};
      {hr, hv, rr, nr, fr, eri, evi, m} = {8'h02, 8'h02, 14'h0020, 17'h00020, 1'b0, 32'h00000080,
         32'h00000080, 32'h00000001};
      go();
   endtask : lock_case
   task automatic ratio_case(input logic [7:0] h, input logic [13:0] a, input logic [16:0] b, input logic f,
      input int e, input int v);
      {rl, vl, sel, asy, dly, lde, hit, drop, m} = {8'h00, 8'h00, 4'h0, 32'h00000000, 32'h00000009,
         32'h00000000};
      {hr, hv, rr, nr, fr, eri, evi} = {h, 8'h02, a, b, f, e, v};
      go();
   endtask : ratio_case
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Readback controls change every cycle so the shared pin sees all its cases
   initial begin
      forever begin
         @(negedge clk);
         tmp = $random(seed);
         {pen, rda, rdd} = {tmp[0], tmp[1] & tmp[2], tmp[3]};
      end
   end
   // Readback owns the pin, and with the flag output off it rests low; lock is checked elsewhere
   always @(posedge clk) begin
      if (rst_b && pin_due) check(50'(pin), 50'(pin_exp));
      pin_due = rst_b && (rda || !pen);
      pin_exp = rda & rdd;
   end
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {cyc, rlast, vlast, viv, uc, dc} = '0;
      end else begin
         cyc++;
         uc += 8'(up);
         dc += 8'(dn);
         if (vt) begin
            viv = 16'(cyc - vlast);
            vlast = cyc;
         end
         if (rt) begin
            if (exp_q.size() > 0) check({lock_s, uc, dc, hiz, 16'(cyc - rlast), viv}, exp_q.pop_front());
            rlast = cyc;
            uc = 8'h00;
            dc = 8'h00;
         end
      end
   end
   initial begin
      {seed, num_errors, total_checks} = {74, 0, 0};
      {rst_b, run, fr, sw, upe, dne, lde, sel, asy, dly, pen, rda, rdd} = '0;
      {hr, hv, rl, vl, rr, nr} = {8'h02, 8'h02, 8'h00, 8'h00, 14'h0001, 17'h00020};
      lock_case(0, 1, 0, 0, 0, 1, 1, 9);
      lock_case(0, 3, 0, 0, 0, 1, 0, 9);
      lock_case(1, 0, 0, 0, 0, 1, 1, 9);
      lock_case(0, 3, 1, 0, 0, 1, 1, 5);
      lock_case(0, 3, 0, 1, 1, 1, 1, 9);
      lock_case(1, 0, 0, 1, 1, 1, 0, 9);
      lock_case(3, 0, 0, 1, 0, 1, 1, 9);
      lock_case(0, 1, 0, 1, 0, 1, 0, 9);
      lock_case(0, 0, 0, 0, 0, 0, 1, 9);
      ratio_case(200, 14'h0000, 17'h00000, 0, 400, 128);
      ratio_case(30, 14'h0003, 17'h00023, 1, 180, 144);
      ratio_case(100, 14'h0001, 17'h00028, 1, 200, 160);
      ratio_case(40, 14'h0002, 17'h00021, 0, 160, 132);
      final_report();
   end
endmodule : pll_core_bench
